// ==== hdl/hop_link_pkg.sv ====
/*
 * hop_link_pkg: constants and carrier types for the hopping link controller.
 * assumes a single 125 MHz clock domain and plain-port configuration.
 */
package hop_link_pkg;
    localparam int          NUM_SEQUENCES   = 6;
    localparam int          CHANS_HIGH_RATE = 26;
    localparam int          CHANS_LOW_RATE  = 50;
    localparam int          CHAN_W          = 6;
    localparam int          SEQ_W           = 3;
    localparam int          ADDR_W          = 32;
    localparam int          KEY_W           = 128;
    localparam int          CUST_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          FIFO_DEPTH      = 32;
    localparam int          CLK_MHZ         = 125;
    localparam int          SLOT_US_DEFAULT = 20000;
    localparam int          SLOT_CYC_DEFAULT = SLOT_US_DEFAULT * CLK_MHZ;
    localparam logic [7:0]  AUTO_REPLY_ON   = 8'h07;
    localparam logic [1:0]  AMODE_FIELD_LSB_MASK = 2'h3;
    localparam logic [7:0]  ASSURED_BIT     = 8'h10;
    localparam logic [7:0]  ENCRYPT_BIT     = 8'h20;
    localparam logic [CHAN_W-1:0] CHAN_ZERO = 6'h00;

    typedef enum logic [1:0] {MODE_SERIAL, MODE_USER, MODE_EXT_USER} addr_mode_t;

    typedef enum logic [1:0] {KEY_NOP, KEY_WRITE, KEY_CLEAR} key_cmd_t;

    // header of a received packet, reported by the radio front end
    typedef struct packed {
        logic [SEQ_W-1:0]  seq;
        logic              high_rate;
        logic              encrypted;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
    } rx_hdr_t;

    // header for an outgoing packet
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic              long_preamble;
        logic              encrypted;
        logic              assured;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
    } tx_hdr_t;
endpackage

// ==== hdl/word_fifo.sv ====
/*
 * word_fifo: flip-flop FIFO with valid/ready on both sides.
 * assumes one clock; reset asynchronous active high.
 */
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;

    assign o_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_valid = (cnt_r != '0);
    assign o_data  = mem_r[rd_r];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_r[wr_r] <= i_data;
    end
endmodule

// ==== hdl/hop_sync_address_filter.sv ====
/*
 * hop_sync_address_filter: hop sequencing, lock tracking, address filtering
 * and key storage for a frequency-hopping link.
 * assumes a radio front end reporting preamble detect and checked headers,
 * and a uart drain consuming received payload bytes.
 */
`timescale 1ns/1ps
module hop_sync_address_filter
    import hop_link_pkg::*;
#(
    parameter int SLOT_CYCLES = SLOT_CYC_DEFAULT
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [SEQ_W-1:0]  i_hop_seq,
    input  wire logic              i_high_rate,
    input  wire logic [7:0]        i_addressing_mode_select,
    input  wire logic [7:0]        i_auto_reply_addressing,
    input  wire logic [ADDR_W-1:0] i_user_source_address,
    input  wire logic [ADDR_W-1:0] i_user_address_mask,
    input  wire logic [ADDR_W-1:0] i_serial_number_addressing,
    input  wire logic [CUST_W-1:0] i_customer_identifier_bytes,
    input  wire logic [ADDR_W-1:0] i_dest_wdata,
    input  wire logic              i_dest_we,
    input  wire key_cmd_t          i_key_cmd,
    input  wire logic [KEY_W-1:0]  i_key_wdata,
    input  wire logic              i_preamble_det,
    input  wire logic              i_rx_done,
    input  wire logic              i_rx_check_ok,
    input  wire rx_hdr_t           i_rx_hdr,
    input  wire logic [DATA_W-1:0] i_rx_data,
    input  wire logic              i_rx_data_valid,
    output logic                   o_rx_data_ready,
    input  wire logic              i_tx_req,
    output logic                   o_tx_start,
    output tx_hdr_t                o_tx_hdr,
    output logic [KEY_W-1:0]       o_cipher_key,
    output logic                   o_key_loaded,
    output logic [CHAN_W-1:0]      o_channel,
    output logic                   o_locked,
    output logic                   o_scanning,
    output logic [ADDR_W-1:0]      o_user_destination_address,
    output logic [DATA_W-1:0]      o_uart_data,
    output logic                   o_uart_valid,
    input  wire logic              i_uart_ready
);
    typedef enum logic [1:0] {ST_SCAN, ST_PAUSE, ST_LOCKED, ST_WAIT} link_state_t;

    localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);

    // the front end strobes are asynchronous to i_clk
    logic [1:0] pre_sync_r;
    logic [1:0] done_sync_r;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pre_sync_r  <= '0;
            done_sync_r <= '0;
        end
        else
        begin
            pre_sync_r  <= {pre_sync_r[0], i_preamble_det};
            done_sync_r <= {done_sync_r[0], i_rx_done};
        end
    end
    logic done_prev_r;
    wire  preamble   = pre_sync_r[1];
    wire  rx_done_ev = done_sync_r[1] && !done_prev_r;

    link_state_t       state_r;
    link_state_t       state_nxt;
    logic [CHAN_W-1:0] chan_r;
    logic [SLOT_W-1:0] slot_r;
    logic              long_pre_r;
    logic [ADDR_W-1:0] udest_r;
    logic [KEY_W-1:0]  key_r;
    logic              key_ok_r;
    logic              tx_r;
    tx_hdr_t           tx_hdr_r;

    wire [CHAN_W-1:0] last_chan = i_high_rate ? CHAN_W'(CHANS_HIGH_RATE - 1)
                                              : CHAN_W'(CHANS_LOW_RATE - 1);
    wire [CHAN_W-1:0] next_chan = (chan_r >= last_chan) ? CHAN_ZERO : chan_r + 1'b1;
    wire              slot_end  = (slot_r == SLOT_W'(SLOT_CYCLES - 1));

    // addressing decode
    wire [1:0]        mode_bits = i_addressing_mode_select[1:0] & AMODE_FIELD_LSB_MASK;
    wire addr_mode_t  tx_mode   = (mode_bits == 2'h0) ? MODE_SERIAL :
                                  (mode_bits == 2'h1) ? MODE_USER : MODE_EXT_USER;
    wire              enc_on    = |(i_addressing_mode_select & ENCRYPT_BIT) && key_ok_r;
    wire              assured   = |(i_addressing_mode_select & ASSURED_BIT);
    wire [ADDR_W-1:0] bcast     = i_user_source_address | i_user_address_mask;
    wire [ADDR_W-1:0] own_src   = (tx_mode == MODE_SERIAL) ? i_serial_number_addressing
                                                           : i_user_source_address;
    // extended user unencrypted carries the customer id in the upper half
    wire [ADDR_W-1:0] ext_dst   = enc_on ? udest_r
                                         : {i_customer_identifier_bytes, udest_r[CUST_W-1:0]};
    wire [ADDR_W-1:0] tx_dst    = (tx_mode == MODE_EXT_USER) ? ext_dst : udest_r;

    // every addressing type checked: exact, serial, or broadcast in our network
    wire [ADDR_W-1:0] net_bits  = ~i_user_address_mask;
    wire hit_exact  = (i_rx_hdr.dst == i_user_source_address);
    wire hit_serial = (i_rx_hdr.dst == i_serial_number_addressing);
    wire hit_bcast  = ((i_rx_hdr.dst & net_bits) == (i_user_source_address & net_bits))
                      && ((i_rx_hdr.dst & i_user_address_mask) == i_user_address_mask);
    wire addr_hit   = hit_exact || hit_serial || hit_bcast;
    // hop sequence and rate must match
    wire seq_match  = (i_rx_hdr.seq == i_hop_seq) && (i_rx_hdr.high_rate == i_high_rate);
    // header only considered once the check passed; wrong key fails it
    wire rx_good    = rx_done_ev && i_rx_check_ok && (!i_rx_hdr.encrypted || key_ok_r);
    wire accept     = rx_good && seq_match && addr_hit;

    // receive gate: payload passes to uart only for an accepted packet
    logic gate_r;
    wire  fifo_in_ready;
    assign o_rx_data_ready = fifo_in_ready;
    wire  fifo_push = i_rx_data_valid && gate_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_SCAN:   if (preamble) state_nxt = ST_PAUSE;
            ST_PAUSE:
            begin
                if (accept)
                    state_nxt = ST_LOCKED;
                else if (rx_done_ev || !preamble)
                    state_nxt = ST_SCAN;
            end
            ST_LOCKED: if (slot_end) state_nxt = ST_WAIT;
            ST_WAIT:
            begin
                if (accept)
                    state_nxt = ST_LOCKED;
                else if (slot_end)
                    state_nxt = ST_SCAN;
            end
            default:   state_nxt = ST_SCAN;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r     <= ST_SCAN;
            done_prev_r <= 1'b0;
            chan_r      <= CHAN_ZERO;
            slot_r      <= '0;
            long_pre_r  <= 1'b1;
            gate_r      <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            done_prev_r <= done_sync_r[1];
            if (state_r == ST_SCAN && !preamble)
                chan_r <= next_chan;
            else if (slot_end && (state_r == ST_LOCKED || state_r == ST_WAIT))
                chan_r <= next_chan;
            if (slot_end || (state_r == ST_PAUSE && accept))
                slot_r <= '0;
            else
                slot_r <= slot_r + 1'b1;
            if (slot_end || chan_r != next_chan && state_r == ST_SCAN)
                long_pre_r <= 1'b1;
            else if (o_tx_start)
                long_pre_r <= 1'b0;
            if (accept)
                gate_r <= 1'b1;
            else if (rx_done_ev)
                gate_r <= 1'b0;
        end
    end

    // destination register: software write, auto-reply capture, broadcast default
    logic dest_init_r;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            udest_r     <= '0;
            dest_init_r <= 1'b0;
        end
        else
        begin
            dest_init_r <= 1'b1;
            if (!dest_init_r)
                udest_r <= bcast;
            else if (accept && i_auto_reply_addressing == AUTO_REPLY_ON)
                udest_r <= i_rx_hdr.src;
            else if (i_dest_we)
                udest_r <= i_dest_wdata;
        end
    end

    // key store: write or clear only, no read port
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            key_r    <= '0;
            key_ok_r <= 1'b0;
        end
        else
        begin
            case (i_key_cmd)
                KEY_WRITE:
                begin
                    key_r    <= i_key_wdata;
                    key_ok_r <= 1'b1;
                end
                KEY_CLEAR:
                begin
                    key_r    <= '0;
                    key_ok_r <= 1'b0;
                end
                default:
                begin
                    key_r    <= key_r;
                    key_ok_r <= key_ok_r;
                end
            endcase
        end
    end

    // transmit: only from scan or from a locked slot on the current channel
    wire tx_go = i_tx_req && !tx_r && (state_r == ST_SCAN || state_r == ST_LOCKED);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_r     <= 1'b0;
            tx_hdr_r <= '0;
        end
        else
        begin
            tx_r <= tx_go;
            if (tx_go)
            begin
                tx_hdr_r.chan          <= chan_r;
                tx_hdr_r.long_preamble <= long_pre_r;
                tx_hdr_r.encrypted     <= enc_on;
                tx_hdr_r.assured       <= assured;
                tx_hdr_r.src           <= own_src;
                tx_hdr_r.dst           <= tx_dst;
            end
        end
    end

    assign o_tx_start   = tx_r;
    assign o_tx_hdr     = tx_hdr_r;
    assign o_cipher_key = key_r; // to the cipher core only
    assign o_key_loaded = key_ok_r;
    assign o_channel    = chan_r;
    assign o_locked     = (state_r == ST_LOCKED) || (state_r == ST_WAIT);
    assign o_scanning   = (state_r == ST_SCAN);
    assign o_user_destination_address = udest_r;

    word_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_data  (i_rx_data),
        .i_valid (fifo_push),
        .o_ready (fifo_in_ready),
        .o_data  (o_uart_data),
        .o_valid (o_uart_valid),
        .i_ready (i_uart_ready)
    );
endmodule

// ==== sim/hop_sync_sva.sv ====
/* hop_sync_sva: port-level properties of the hop link controller.
   assumes a bind onto hop_sync_address_filter and a single clock domain. */
`timescale 1ns/1ps
module hop_sync_sva
    import hop_link_pkg::*;
#(
    parameter int SLOT_CYCLES = 50
) (
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire logic              i_high_rate,
    input wire logic              i_tx_req,
    input wire key_cmd_t          i_key_cmd,
    input wire logic [KEY_W-1:0]  i_key_wdata,
    input wire logic [ADDR_W-1:0] i_user_source_address,
    input wire logic [ADDR_W-1:0] i_user_address_mask,
    input wire logic              o_tx_start,
    input wire logic [KEY_W-1:0]  o_cipher_key,
    input wire logic              o_key_loaded,
    input wire logic [CHAN_W-1:0] o_channel,
    input wire logic              o_locked,
    input wire logic              o_scanning,
    input wire logic [ADDR_W-1:0] o_user_destination_address
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [31:0]       hold_cnt_r;
    logic [CHAN_W-1:0] chan_q_r;
    // cycles locked since lock was gained or since the last hop
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            hold_cnt_r <= '0;
            chan_q_r   <= '0;
        end
        else
        begin
            chan_q_r <= o_channel;
            if (!o_locked)
                hold_cnt_r <= '0;
            else if (o_channel != chan_q_r)
                hold_cnt_r <= 32'h1;
            else
                hold_cnt_r <= hold_cnt_r + 32'h1;
        end
    property p_lock_excl; o_locked |-> !o_scanning; endproperty
    a_lock_excl: assert property (p_lock_excl) else $error("locked while scanning");
    property p_tx_cause; o_tx_start |-> $past(i_tx_req); endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("start without request");
    property p_lock_hold;
        o_locked && $past(o_locked) && !$stable(o_channel) |-> hold_cnt_r == SLOT_CYCLES;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("channel moved in slot");
    property p_hop; o_locked && hold_cnt_r == SLOT_CYCLES |-> !$stable(o_channel); endproperty
    a_hop: assert property (p_hop) else $error("no hop at slot end");
    property p_wait_bound; o_locked |-> hold_cnt_r <= SLOT_CYCLES; endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("waited past slot");
    property p_key_wr;
        i_key_cmd == KEY_WRITE |=> o_key_loaded && o_cipher_key == $past(i_key_wdata);
    endproperty
    a_key_wr: assert property (p_key_wr) else $error("key not stored");
    property p_key_clr; i_key_cmd == KEY_CLEAR |=> !o_key_loaded && o_cipher_key == '0; endproperty
    a_key_clr: assert property (p_key_clr) else $error("key not cleared");
    property p_chan_range;
        o_channel < (i_high_rate ? CHAN_W'(CHANS_HIGH_RATE) : CHAN_W'(CHANS_LOW_RATE));
    endproperty
    a_chan_range: assert property (p_chan_range) else $error("channel out of range");
    property p_bcast;
        $fell(i_rst) |=> o_user_destination_address ==
            ($past(i_user_source_address) | $past(i_user_address_mask));
    endproperty
    a_bcast: assert property (p_bcast) else $error("destination not broadcast");
endmodule
bind hop_sync_address_filter hop_sync_sva #(.SLOT_CYCLES(SLOT_CYCLES)) hop_sync_sva_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_high_rate(i_high_rate), .i_tx_req(i_tx_req),
    .i_key_cmd(i_key_cmd), .i_key_wdata(i_key_wdata), .o_tx_start(o_tx_start),
    .i_user_source_address(i_user_source_address), .i_user_address_mask(i_user_address_mask),
    .o_cipher_key(o_cipher_key), .o_key_loaded(o_key_loaded), .o_channel(o_channel),
    .o_locked(o_locked), .o_scanning(o_scanning),
    .o_user_destination_address(o_user_destination_address));

// ==== sim/hop_peer_model.sv ====
/* hop_peer_model: behavioural peer transceiver feeding the receive side.
   assumes the bench calls its tasks just after a rising clock edge. */
`timescale 1ns/1ps
module hop_peer_model
    import hop_link_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rx_data_ready,
    output logic              o_preamble_det = 1'b0,
    output logic              o_rx_done = 1'b0,
    output logic              o_rx_check_ok = 1'b0,
    output rx_hdr_t           o_rx_hdr = '0,
    output logic [DATA_W-1:0] o_rx_data = '0,
    output logic              o_rx_data_valid = 1'b0
);
    // preamble, then a checked header held while the packet end is synchronised
    task automatic frame(input rx_hdr_t hdr, input logic ok);
        o_preamble_det = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        o_rx_hdr = hdr;
        o_rx_check_ok = ok;
        o_rx_done = 1'b1;
        repeat (6) @(posedge i_clk);
        #1;
        o_rx_hdr = ~hdr;
        o_rx_check_ok = ~ok;
        o_rx_done = 1'b0;
        o_preamble_det = 1'b0;
    endtask
    task automatic put(input logic [DATA_W-1:0] b);
        o_rx_data = b;
        o_rx_data_valid = 1'b1;
        while (!i_rx_data_ready)
        begin
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        #1;
    endtask
    // a released data line shows the inverse of its last byte
    task automatic idle();
        o_rx_data_valid = 1'b0;
        o_rx_data = ~o_rx_data;
    endtask
endmodule

// ==== sim/tb_top.sv ====
/* tb_top: self-checking bench for the hop link controller.
   assumes the peer model drives the receive side; the slot is cut to 50 cycles. */
`timescale 1ns/1ps
module tb_top;
    import hop_link_pkg::*;
    localparam int                SLOT = 50;
    localparam logic [ADDR_W-1:0] SRC  = 32'h76543200;
    localparam logic [ADDR_W-1:0] MASK = 32'h000000ff;
    localparam logic [ADDR_W-1:0] SER  = 32'h00c0ffee;
    localparam logic [CUST_W-1:0] CUST = 16'h4a3b;
    localparam logic [KEY_W-1:0]  KEY  = 128'h0123456789abcdef0f1e2d3c4b5a6978;
    localparam rx_hdr_t           GOOD = '{3'h2, 1'b1, 1'b0, 32'h76543205, SRC | MASK};
    logic              i_clk, i_rst, i_high_rate, i_preamble_det, i_rx_done, i_rx_check_ok;
    logic              i_rx_data_valid, o_rx_data_ready, o_tx_start, o_key_loaded, o_locked;
    logic              o_scanning, o_uart_valid, i_tx_req = 1'b0, i_dest_we = 1'b0;
    logic              i_uart_ready = 1'b0;
    logic [7:0]        i_addressing_mode_select = 8'h12, i_auto_reply_addressing = 8'h07;
    logic [ADDR_W-1:0] i_dest_wdata = '0, o_user_destination_address;
    key_cmd_t          i_key_cmd = KEY_NOP;
    logic [KEY_W-1:0]  i_key_wdata = '0, o_cipher_key;
    rx_hdr_t           i_rx_hdr;
    tx_hdr_t           o_tx_hdr;
    logic [DATA_W-1:0] i_rx_data, o_uart_data;
    logic [CHAN_W-1:0] o_channel;
    int                err_total = 0, total_checks = 0;
    hop_sync_address_filter #(.SLOT_CYCLES(SLOT)) hop_sync_address_filter_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_hop_seq(3'h2), .i_high_rate(i_high_rate),
        .i_addressing_mode_select(i_addressing_mode_select), .i_user_address_mask(MASK),
        .i_auto_reply_addressing(i_auto_reply_addressing), .i_user_source_address(SRC),
        .i_serial_number_addressing(SER), .i_customer_identifier_bytes(CUST),
        .i_dest_wdata(i_dest_wdata), .i_dest_we(i_dest_we), .i_key_cmd(i_key_cmd),
        .i_key_wdata(i_key_wdata), .i_preamble_det(i_preamble_det), .i_rx_done(i_rx_done),
        .i_rx_check_ok(i_rx_check_ok), .i_rx_hdr(i_rx_hdr), .i_rx_data(i_rx_data),
        .i_rx_data_valid(i_rx_data_valid), .o_rx_data_ready(o_rx_data_ready),
        .i_tx_req(i_tx_req), .o_tx_start(o_tx_start), .o_tx_hdr(o_tx_hdr),
        .o_cipher_key(o_cipher_key), .o_key_loaded(o_key_loaded), .o_channel(o_channel),
        .o_locked(o_locked), .o_scanning(o_scanning), .o_uart_data(o_uart_data),
        .o_user_destination_address(o_user_destination_address),
        .o_uart_valid(o_uart_valid), .i_uart_ready(i_uart_ready));
    hop_peer_model hop_peer_model_inst (
        .i_clk(i_clk), .i_rx_data_ready(o_rx_data_ready), .o_preamble_det(i_preamble_det),
        .o_rx_done(i_rx_done), .o_rx_check_ok(i_rx_check_ok), .o_rx_hdr(i_rx_hdr),
        .o_rx_data(i_rx_data), .o_rx_data_valid(i_rx_data_valid));
    task automatic check(input logic [KEY_W-1:0] seen, input logic [KEY_W-1:0] want);
        total_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic conclude();
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_reset(input logic rate);
        i_rst = 1'b1;
        i_high_rate = rate;
        cyc(6);
        i_rst = 1'b0;
        cyc(2);
        check(o_user_destination_address, SRC | MASK);
        check({o_scanning, o_locked, o_key_loaded}, 3'h4);
        check(o_cipher_key, '0);
    endtask
    task automatic t_scan(input int n);
        for (int k = 0; k < 2 * n && o_channel != CHAN_W'(n - 2); k++)
            cyc(1);
        cyc(1);
        check(o_channel, n - 1);
        cyc(1);
        check(o_channel, 0);
    endtask
    task automatic t_refuse();
        rx_hdr_t h;
        for (int k = 0; k < 5; k++)
        begin
            h = GOOD;
            case (k)
                1: h.seq = 3'h3;
                2: h.high_rate = 1'b0;
                3: h.dst = 32'h11111105;
                4: h.encrypted = 1'b1;
                default: ;
            endcase
            hop_peer_model_inst.frame(h, k != 0);
            hop_peer_model_inst.put(8'h5a);
            hop_peer_model_inst.idle();
            cyc(3);
            check(o_locked, 1'b0);
            check(o_uart_valid, 1'b0);
        end
    endtask
    task automatic t_link();
        logic [7:0] modes [4] = '{8'h12, 8'h00, 8'h01, 8'h03};
        hop_peer_model_inst.frame(GOOD, 1'b1);
        check(o_locked, 1'b1);
        check(o_user_destination_address, GOOD.src);
        for (int k = 0; k < 4; k++)
        begin
            i_addressing_mode_select = modes[k];
            i_tx_req = 1'b1;
            cyc(1);
            i_tx_req = 1'b0;
            check(o_tx_start, 1'b1);
            check(o_tx_hdr.long_preamble, k == 0);
            check(o_tx_hdr.assured, modes[k][4]);
            if (k != 2)
                check(o_tx_hdr.src, k == 1 ? SER : SRC);
            if (k == 0)
                check(o_tx_hdr.dst[31:16], CUST);
            cyc(1);
        end
    endtask
    task automatic t_hop();
        logic [CHAN_W-1:0] ch = o_channel;
        int                n;
        for (n = 0; n < 2 * SLOT && o_channel == ch; n++)
            cyc(1);
        check({o_locked, o_scanning}, 2'h2);
        if (ch == CHAN_W'(CHANS_HIGH_RATE - 1))
            check(o_channel, 0);
        else
            check(o_channel, ch + 1);
        for (n = 0; n < 2 * SLOT && o_locked; n++)
            cyc(1);
        check({o_locked, o_scanning}, 2'h1);
        check(n, SLOT);
    endtask
    task automatic t_key();
        rx_hdr_t h = GOOD;
        h.encrypted = 1'b1;
        i_key_cmd = KEY_WRITE;
        i_key_wdata = KEY;
        cyc(1);
        i_key_cmd = KEY_NOP;
        i_key_wdata = ~KEY;
        check(o_key_loaded, 1'b1);
        check(o_cipher_key, KEY);
        hop_peer_model_inst.frame(h, 1'b1);
        check(o_locked, 1'b1);
        i_addressing_mode_select = 8'h22;
        i_tx_req = 1'b1;
        cyc(1);
        i_tx_req = 1'b0;
        check(o_tx_hdr.encrypted, 1'b1);
        check(o_tx_hdr.dst, GOOD.src);
        check(o_tx_hdr.chan, o_channel);
        i_addressing_mode_select = 8'h03;
        i_key_cmd = KEY_CLEAR;
        cyc(1);
        i_key_cmd = KEY_NOP;
        check({o_key_loaded, o_cipher_key != '0}, 2'h0);
        i_dest_we = 1'b1;
        i_dest_wdata = 32'h0badcafe;
        cyc(1);
        i_dest_we = 1'b0;
        check(o_user_destination_address, 32'h0badcafe);
    endtask
    task automatic t_fifo();
        i_auto_reply_addressing = 8'h00;
        hop_peer_model_inst.frame(GOOD, 1'b1);
        check(o_user_destination_address, 32'h0badcafe);
        for (int k = 0; k < FIFO_DEPTH; k++)
            hop_peer_model_inst.put(8'(k) ^ 8'ha5);
        hop_peer_model_inst.idle();
        check(o_rx_data_ready, 1'b0);
        for (int k = 0; k < FIFO_DEPTH; k++)
        begin
            cyc(1);
            i_uart_ready = 1'b1;
            check({o_uart_valid, o_uart_data}, {1'b1, 8'(k) ^ 8'ha5});
            cyc(1);
            i_uart_ready = 1'b0;
        end
        cyc(2);
        check(o_uart_valid, 1'b0);
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial
    begin
        #160000;
        err_total++;
        conclude();
    end
    initial
    begin
        t_reset(1'b1);
        t_scan(CHANS_HIGH_RATE);
        t_refuse();
        t_link();
        t_hop();
        t_key();
        t_hop();
        t_fifo();
        t_reset(1'b0);
        t_scan(CHANS_LOW_RATE);
        conclude();
    end
endmodule
